// >>> rtl/mre_params.svh
// constants for the move and return instruction executor
`ifndef MRE_PARAMS_SVH
`define MRE_PARAMS_SVH

// ==========================================================
// instruction word layout
`define MRE_INSTR_W 14
`define MRE_FADDR_W 7
`define MRE_DATA_W 8

// ==========================================================
// opcode masks and match values
`define MRE_COPY_MASK 14'h3f80
`define MRE_COPY_MATCH 14'h0080
`define MRE_NOP_MASK 14'h3f9f
`define MRE_NOP_MATCH 14'h0000
`define MRE_RET_ISR_CODE 14'h0009
`define MRE_RETURN_CODE 14'h0008
`define MRE_LIT_MASK 14'h3c00
`define MRE_LOADLIT_MATCH 14'h3000
`define MRE_RETLIT_MATCH 14'h3400

// ==========================================================
// interrupt control register
`define MRE_IRQ_CTRL_ADDR 7'h70
`define MRE_GIE_BIT 7
`define MRE_IRQ_CTRL_RESET 8'h00

// ==========================================================
// reset values and timing
`define MRE_ACC_RESET 8'h00
`define MRE_RET_CYCLES 2
`define MRE_PLAIN_CYCLES 1

`endif

// >>> rtl/mre_pkg.sv
// types for the move and return instruction executor
package mre_pkg;

  // execution sequencer states
  typedef enum logic [1:0] {
    MRE_ST_EXEC = 2'h1,
    MRE_ST_SECOND = 2'h2
  } mre_state_e;

  // decoded instruction class
  typedef enum logic [6:0] {
    MRE_OP_OTHER = 7'h01,
    MRE_OP_COPY = 7'h02,
    MRE_OP_LOADLIT = 7'h04,
    MRE_OP_NOP = 7'h08,
    MRE_OP_RET_ISR = 7'h10,
    MRE_OP_RETLIT = 7'h20,
    MRE_OP_RETURN = 7'h40
  } mre_op_e;

endpackage

// >>> rtl/mre_file_ram.sv
// file register memory with registered read data
`timescale 1ns/1ps

module mre_file_ram #(
  parameter int ADDR_W = 7,
  parameter int DATA_W = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data
);

  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // ==========================================================
  // storage, no reset on the array itself
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // ==========================================================
  // read data register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// >>> rtl/mre_exec.sv
// executor for move, literal load, no-op and return instructions
`timescale 1ns/1ps
`include "mre_params.svh"

module mre_exec #(
  parameter int PC_W = 13,
  parameter int STACK_DEPTH = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire logic [`MRE_INSTR_W-1:0] instr,
  output logic instr_ready,
  input wire logic push_valid,
  input wire logic [PC_W-1:0] push_addr,
  input wire logic [`MRE_FADDR_W-1:0] peek_addr,
  output logic [`MRE_DATA_W-1:0] peek_data,
  output logic [PC_W-1:0] pc,
  output logic [`MRE_DATA_W-1:0] acc,
  output logic [`MRE_DATA_W-1:0] irq_control_reg,
  output logic global_irq_enable,
  output logic stack_pop
);
  import mre_pkg::*;

  localparam int SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

  mre_state_e state;
  mre_state_e next_state;
  mre_op_e op;
  logic take;
  logic [PC_W-1:0] next_pc;
  logic [`MRE_DATA_W-1:0] next_acc;
  logic [`MRE_DATA_W-1:0] next_irq_control_reg;
  logic next_instr_ready;
  logic next_stack_pop;
  logic [SP_W-1:0] sp;
  logic [SP_W-1:0] next_sp;
  logic [PC_W-1:0] stack_mem [0:STACK_DEPTH-1];
  logic [PC_W-1:0] stack_top;
  logic do_pop;
  logic do_push;
  logic file_we;
  logic [`MRE_FADDR_W-1:0] file_addr;
  logic [`MRE_DATA_W-1:0] lit;

  assign lit = instr[`MRE_DATA_W-1:0];
  assign file_addr = instr[`MRE_FADDR_W-1:0];
  assign take = instr_valid && instr_ready;

  // ==========================================================
  // instruction decode
  always_comb begin
    if ((instr & `MRE_COPY_MASK) == `MRE_COPY_MATCH) begin
      op = MRE_OP_COPY;
    end else if (instr == `MRE_RET_ISR_CODE) begin
      op = MRE_OP_RET_ISR;
    end else if (instr == `MRE_RETURN_CODE) begin
      op = MRE_OP_RETURN;
    end else if ((instr & `MRE_NOP_MASK) == `MRE_NOP_MATCH) begin
      op = MRE_OP_NOP;
    end else if ((instr & `MRE_LIT_MASK) == `MRE_LOADLIT_MATCH) begin
      op = MRE_OP_LOADLIT;
    end else if ((instr & `MRE_LIT_MASK) == `MRE_RETLIT_MATCH) begin
      op = MRE_OP_RETLIT;
    end else begin
      op = MRE_OP_OTHER;
    end
  end

  // ==========================================================
  // call stack, circular like the hardware stack it models
  assign stack_top = stack_mem[sp];

  // stack pointer next value; a pop and a push together cancel
  always_comb begin
    next_sp = sp;
    if (do_push && !do_pop) begin
      next_sp = sp + SP_W'(1);
    end else if (do_pop && !do_push) begin
      next_sp = sp - SP_W'(1);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sp <= '0;
    end else begin
      sp <= next_sp;
    end
  end

  // one register per stack entry; push writes the slot above the top, or the top slot itself when a pop comes in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < STACK_DEPTH; gi = gi + 1) begin : g_stack
      logic [PC_W-1:0] next_entry;
      logic [SP_W-1:0] wr_slot;
      always_comb begin
        wr_slot = do_pop ? sp : sp + SP_W'(1);
        next_entry = stack_mem[gi];
        if (do_push && (wr_slot == SP_W'(gi))) begin
          next_entry = push_addr;
        end
      end
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          stack_mem[gi] <= '0;
        end else begin
          stack_mem[gi] <= next_entry;
        end
      end
    end
  endgenerate

  // ==========================================================
  // execution next values
  always_comb begin
    next_state = state;
    next_pc = pc;
    next_acc = acc;
    next_irq_control_reg = irq_control_reg;
    next_instr_ready = instr_ready;
    next_stack_pop = 1'b0;
    do_pop = 1'b0;
    do_push = push_valid;
    file_we = 1'b0;
    case (state)
      MRE_ST_EXEC: begin
        if (take) begin
          next_pc = pc + PC_W'(1);
          case (op)
            MRE_OP_COPY: begin
              file_we = 1'b1;
              if (file_addr == `MRE_IRQ_CTRL_ADDR) begin
                next_irq_control_reg = acc;
              end
            end
            MRE_OP_LOADLIT: begin
              next_acc = lit;
            end
            MRE_OP_RET_ISR: begin
              do_pop = 1'b1;
              next_pc = stack_top;
              next_irq_control_reg[`MRE_GIE_BIT] = 1'b1;
            end
            MRE_OP_RETLIT: begin
              next_acc = lit;
              do_pop = 1'b1;
              next_pc = stack_top;
            end
            MRE_OP_RETURN: begin
              do_pop = 1'b1;
              next_pc = stack_top;
            end
            default: begin
              next_pc = pc + PC_W'(1);
            end
          endcase
          if (do_pop) begin
            next_state = MRE_ST_SECOND;
            next_instr_ready = 1'b0;
            next_stack_pop = 1'b1;
          end
        end
      end
      MRE_ST_SECOND: begin
        // dead cycle while the fetched word is discarded
        next_state = MRE_ST_EXEC;
        next_instr_ready = 1'b1;
      end
      default: begin
        next_state = MRE_ST_EXEC;
        next_instr_ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= MRE_ST_EXEC;
      pc <= '0;
      acc <= `MRE_ACC_RESET;
      irq_control_reg <= `MRE_IRQ_CTRL_RESET;
      global_irq_enable <= 1'b0;
      instr_ready <= 1'b1;
      stack_pop <= 1'b0;
    end else begin
      state <= next_state;
      pc <= next_pc;
      acc <= next_acc;
      irq_control_reg <= next_irq_control_reg;
      global_irq_enable <= next_irq_control_reg[`MRE_GIE_BIT];
      instr_ready <= next_instr_ready;
      stack_pop <= next_stack_pop;
    end
  end

  // ==========================================================
  // file register memory
  mre_file_ram #(
    .ADDR_W(`MRE_FADDR_W),
    .DATA_W(`MRE_DATA_W)
  ) u_file_ram (
    .clock(clock),
    .resetn(resetn),
    .wr_en(file_we),
    .wr_addr(file_addr),
    .wr_data(acc),
    .rd_addr(peek_addr),
    .rd_data(peek_data)
  );

endmodule

// >>> verif/mre_monitor.sv
// assertion checker for the move and return executor
`timescale 1ns/1ps
`include "mre_params.svh"

module mre_monitor #(
  parameter int PC_W = 13
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire logic [`MRE_INSTR_W-1:0] instr,
  input wire logic instr_ready,
  input wire logic [PC_W-1:0] pc,
  input wire logic [`MRE_DATA_W-1:0] acc,
  input wire logic [`MRE_DATA_W-1:0] irq_control_reg,
  input wire logic global_irq_enable,
  input wire logic stack_pop
);
  logic take, is_copy, is_nop, is_lit, is_rl, is_ret;

  // ==================================================
  // decode of the word taken at each edge
  assign take = instr_valid && instr_ready;
  assign is_copy = (instr & `MRE_COPY_MASK) == `MRE_COPY_MATCH;
  assign is_nop = (instr & `MRE_NOP_MASK) == `MRE_NOP_MATCH;
  assign is_lit = (instr & `MRE_LIT_MASK) == `MRE_LOADLIT_MATCH;
  assign is_rl = (instr & `MRE_LIT_MASK) == `MRE_RETLIT_MATCH;
  assign is_ret = is_rl || instr == `MRE_RET_ISR_CODE
    || instr == `MRE_RETURN_CODE;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // ==================================================
  // properties
  copy_irq_a: assert property (
    take && is_copy && instr[6:0] == `MRE_IRQ_CTRL_ADDR
    |=> irq_control_reg == $past(acc)) else $error("copy lost");
  plain_step_a: assert property (
    take && (is_copy || is_nop) |=> pc == PC_W'($past(pc) + 1)
    && $stable(acc) && instr_ready) else $error("plain step wrong");
  load_lit_a: assert property (
    take && is_lit |=> acc == $past(instr[7:0]) && instr_ready)
    else $error("literal load wrong");
  retlit_acc_a: assert property (
    take && is_rl |=> acc == $past(instr[7:0]))
    else $error("return literal wrong");
  isr_gie_a: assert property (
    take && instr == `MRE_RET_ISR_CODE
    |=> global_irq_enable && irq_control_reg[7] && $stable(acc))
    else $error("enable bit not set");
  ret_busy_a: assert property (
    take && is_ret |=> !instr_ready ##1 instr_ready)
    else $error("return length wrong");
  ret_pop_a: assert property (
    take && is_ret |=> stack_pop ##1 !stack_pop)
    else $error("pop pulse wrong");
  pop_cause_a: assert property (
    $rose(stack_pop) |-> $past(take && is_ret))
    else $error("pop without return");
  ret_keep_a: assert property (
    take && instr == `MRE_RETURN_CODE
    |=> $stable(acc) && $stable(irq_control_reg))
    else $error("return changed state");
  nop_keep_a: assert property (
    take && is_nop |=> $stable(irq_control_reg) && !stack_pop)
    else $error("no-op changed state");
endmodule

// >>> verif/mre_prog_model.sv
// program memory model feeding the instruction stream
`timescale 1ns/1ps

module mre_prog_model (
  input wire logic run_en,
  input wire logic [12:0] pc,
  output logic instr_valid,
  output logic [13:0] instr
);
  logic [13:0] mem [16];

  // blank memory until the bench loads a program
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 14'h0000;
  end

  // fetch at pc; idle word is inverted so it never looks held
  always_comb begin
    instr_valid = run_en;
    instr = run_en ? mem[pc[3:0]] : ~mem[pc[3:0]];
  end
endmodule

// >>> verif/mre_exec_tb.sv
// self-checking bench for the move and return executor
`timescale 1ns/1ps

module mre_exec_tb;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic run_en = 1'b0;
  logic push_valid = 1'b0;
  logic [12:0] push_addr = 13'h0000;
  logic [6:0] peek_addr = 7'h00;
  logic instr_valid, instr_ready, global_irq_enable, stack_pop;
  logic [13:0] instr;
  logic [12:0] pc;
  logic [7:0] peek_data, acc, irq_control_reg;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;

  mre_exec #(.PC_W(13), .STACK_DEPTH(8)) mre_exec_inst (.clock, .resetn,
    .instr_valid, .instr, .instr_ready, .push_valid, .push_addr,
    .peek_addr, .peek_data, .pc, .acc, .irq_control_reg,
    .global_irq_enable, .stack_pop);
  mre_prog_model mre_prog_model_inst (.run_en, .pc, .instr_valid, .instr);

  // ==================================================
  // clock and hang guard
  initial begin
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 1000) begin
      bad_count++;
      stop_test;
    end
  end

  // ==================================================
  // helpers
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task do_reset;
    @(negedge clock) resetn = 1'b0;
    repeat (2) @(negedge clock);
    resetn = 1'b1;
  endtask
  task run(input int n);
    @(negedge clock) run_en = 1'b1;
    repeat (n) @(negedge clock);
    run_en = 1'b0;
  endtask
  task push(input logic [12:0] a);
    @(negedge clock) push_valid = 1'b1;
    push_addr = a;
    @(negedge clock) push_valid = 1'b0;
  endtask

  // ==================================================
  // scenarios
  task test_move;
    do_reset;
    chk(16'(pc), 16'h0000);
    chk(16'(instr_ready), 16'h0001);
    // literal words keep spare bits zero
    mre_prog_model_inst.mem[0] = 14'h30a5;
    mre_prog_model_inst.mem[1] = 14'h00a3;
    for (int i = 0; i < 4; i++) mre_prog_model_inst.mem[2 + i] = 14'(i << 5);
    mre_prog_model_inst.mem[6] = 14'h3080;
    mre_prog_model_inst.mem[7] = 14'h00f0;
    run(8);
    chk(16'(pc), 16'h0008);
    chk(16'(acc), 16'h0080);
    chk(16'(irq_control_reg), 16'h0080);
    peek_addr = 7'h23;
    repeat (2) @(negedge clock);
    chk(16'(peek_data), 16'h00a5);
  endtask
  task test_return;
    do_reset;
    push(13'h000c);
    push(13'h0008);
    push(13'h0004);
    mre_prog_model_inst.mem[0] = 14'h3477;
    mre_prog_model_inst.mem[4] = 14'h0009;
    mre_prog_model_inst.mem[8] = 14'h0008;
    mre_prog_model_inst.mem[12] = 14'h3011;
    mre_prog_model_inst.mem[13] = 14'h0100;
    chk(16'(global_irq_enable), 16'h0000);
    run(6);
    chk(16'(pc), 16'h000c);
    chk(16'(acc), 16'h0077);
    chk(16'(global_irq_enable), 16'h0001);
    chk(16'(irq_control_reg), 16'h0080);
    // literal load, then an undecoded word that only steps the pc
    run(2);
    chk(16'(pc), 16'h000e);
    chk(16'(acc), 16'h0011);
  endtask

  // ==================================================
  // verdict and main sequence
  task stop_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    test_move;
    test_return;
    stop_test;
  end
endmodule

bind mre_exec mre_monitor #(.PC_W(PC_W)) mre_monitor_inst (.clock, .resetn,
  .instr_valid, .instr, .instr_ready, .pc, .acc, .irq_control_reg,
  .global_irq_enable, .stack_pop);
